/* hw/asx_core.sv */
// Purpose: asynchronous serial transmit and receive core
// Assumes: ser_tick is a one-cycle pulse at sixteen times the bit rate
// Notes:   receive frames pass a two-entry buffer before the receive buffer
// Overview of operation
// - writing transmit register starts frame immediately
// - start, parity, stop bits added automatically
// - frame shifted out raises transmit end
// - reset empties register without transmit end
// - write during frame is ignored
// - receive sampling only while enable set
// - start confirmed low after eight ticks
// - frame ends after first stop bit
// - frame copied to buffer, receive end
// - errored frame loaded, both requests together
// - enable cleared aborts silently, state kept
// - mode top bit always reads one
// - unread buffer on completion sets overrun
// - parity mismatch sets parity error
// - bad stop sample sets framing error
// - error flag and error request together
// - flags clear on buffer read or frame
// - status upper five bits read zero
// - every completed transmit frame raises transmit end
// - zero parity sends zero, never checks
// - bit time is sixteen serial ticks
// - frame format chosen by mode fields
`timescale 1ns/100ps
`include "asx_map.svh"
module asx_core import asx_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // serial clock enable
  input  wire logic       ser_tick,
  // mode register access
  input  wire logic       mode_wr,
  input  wire logic [7:0] mode_wdata,
  output logic [7:0]      uart_mode_reg,
  // transmit side
  input  wire logic       tx_wr,
  input  wire logic [7:0] tx_wdata,
  output logic            txd,
  output logic            tx_busy,
  output logic            tx_end_irq,
  // receive side
  input  wire logic       rxd,
  input  wire logic       rx_rd,
  output logic [7:0]      receive_buffer,
  output logic [7:0]      rx_error_status,
  output logic            rx_end_irq,
  output logic            rx_error_irq
);
  // ****************************************
  // mode register
  // ****************************************
  logic [7:0] mode_r;
  logic       receive_enable_bit;
  logic [1:0] par_mode;
  logic       char_len_bit;
  logic       stop_len_bit;

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r <= `ASX_MODE_RESET;
    end else if (mode_wr) begin
      mode_r <= mode_wdata | `ASX_MODE_RESET;
    end
  end

  assign receive_enable_bit = mode_r[`ASX_MODE_RXE];
  assign par_mode           = {mode_r[`ASX_MODE_PS_HI], mode_r[`ASX_MODE_PS_LO]};
  assign char_len_bit       = mode_r[`ASX_MODE_CL];
  assign stop_len_bit       = mode_r[`ASX_MODE_SL];

  always_ff @(posedge clk) begin
    if (reset) begin
      uart_mode_reg <= `ASX_MODE_RESET;
    end else begin
      uart_mode_reg <= mode_r;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  asx_tx_state_t tx_st_r;
  logic [11:0]   tx_sh_r;
  logic [3:0]    tx_left_r;
  logic [3:0]    tx_tick_r;
  logic          tx_par;
  logic [7:0]    tx_ch;
  logic [3:0]    tx_len;

  assign tx_ch = char_len_bit ? tx_wdata : {1'b0, tx_wdata[6:0]};

  always_comb begin
    case (par_mode)
      `ASX_PAR_ODD:  tx_par = ~(^tx_ch);
      `ASX_PAR_EVEN: tx_par = ^tx_ch;
      default:       tx_par = (par_mode == `ASX_PAR_NONE); // zero sends 0, none sends stop level
    endcase
  end

  // bits after start: char, parity, stops
  assign tx_len = 4'h7 + {3'h0, char_len_bit} + {3'h0, par_mode != `ASX_PAR_NONE}
                + {3'h0, stop_len_bit} + 4'h1;

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_st_r    <= ASX_TX_IDLE;
      tx_sh_r    <= 12'hfff;
      tx_left_r  <= 4'h0;
      tx_tick_r  <= 4'h0;
      tx_end_irq <= 1'b0;
      txd        <= 1'b1;
      tx_busy    <= 1'b0;
    end else begin
      tx_end_irq <= 1'b0;
      case (tx_st_r)
        ASX_TX_IDLE: begin
          if (tx_wr) begin
            if (char_len_bit) begin
              tx_sh_r <= {2'h3, tx_par, tx_ch, 1'b0};
            end else begin
              tx_sh_r <= {3'h7, tx_par, tx_ch[6:0], 1'b0};
            end
            tx_left_r <= tx_len;
            tx_tick_r <= 4'h0;
            txd       <= 1'b0;
            tx_busy   <= 1'b1;
            tx_st_r   <= ASX_TX_SHIFT;
          end
        end
        ASX_TX_SHIFT: begin
          if (ser_tick) begin
            tx_tick_r <= tx_tick_r + 4'h1;
            if (tx_tick_r == `ASX_LAST_TICK) begin
              if (tx_left_r == 4'h0) begin
                tx_st_r    <= ASX_TX_IDLE;
                tx_busy    <= 1'b0;
                tx_end_irq <= 1'b1;
                txd        <= 1'b1;
              end else begin
                tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
                txd       <= tx_sh_r[1];
                tx_left_r <= tx_left_r - 4'h1;
              end
            end
          end
        end
        default: tx_st_r <= ASX_TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // receive pin synchroniser
  // ****************************************
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_s3_r;
  logic rx_lvl_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_s1_r  <= 1'b1;
      rx_s2_r  <= 1'b1;
      rx_s3_r  <= 1'b1;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_lvl_r <= rx_s3_r;
      end
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  asx_rx_state_t rx_st_r;
  logic [3:0]    rx_tick_r;
  logic [3:0]    rx_idx_r;
  logic [8:0]    rx_sh_r;
  logic [3:0]    rx_last;
  logic          rx_done;
  logic [10:0]   rx_frame;
  logic          fb_ready;
  logic          fb_valid;
  logic [10:0]   fb_data;
  logic          par_exp;
  logic [7:0]    rx_ch;
  logic          rx_parbit;
  logic          rx_perr;
  logic          rx_ferr;

  // index of the first stop bit
  assign rx_last = 4'h7 + {3'h0, char_len_bit} + {3'h0, par_mode != `ASX_PAR_NONE};

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_st_r   <= ASX_RX_IDLE;
      rx_tick_r <= 4'h0;
      rx_idx_r  <= 4'h0;
      rx_sh_r   <= 9'h000;
      rx_done   <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!receive_enable_bit) begin
        rx_st_r <= ASX_RX_IDLE;
      end else if (ser_tick) begin
        case (rx_st_r)
          ASX_RX_IDLE: begin
            if (!rx_lvl_r) begin
              rx_tick_r <= 4'h0;
              rx_st_r   <= ASX_RX_START;
            end
          end
          ASX_RX_START: begin
            rx_tick_r <= rx_tick_r + 4'h1;
            if (rx_tick_r == `ASX_HALF_BIT) begin
              rx_tick_r <= 4'h0;
              rx_idx_r  <= 4'h0;
              rx_st_r   <= rx_lvl_r ? ASX_RX_IDLE : ASX_RX_DATA;
            end
          end
          ASX_RX_DATA: begin
            rx_tick_r <= rx_tick_r + 4'h1;
            if (rx_tick_r == `ASX_LAST_TICK) begin
              if (rx_idx_r == rx_last) begin
                rx_st_r <= ASX_RX_IDLE;
                rx_done <= fb_ready;
              end else begin
                rx_idx_r <= rx_idx_r + 4'h1;
                rx_sh_r  <= {rx_lvl_r, rx_sh_r[8:1]};
              end
            end
          end
          default: rx_st_r <= ASX_RX_IDLE;
        endcase
      end
    end
  end

  // align to lsb by length
  always_comb begin
    case ({char_len_bit, par_mode != `ASX_PAR_NONE})
      2'h3:    begin rx_ch = rx_sh_r[7:0]; rx_parbit = rx_sh_r[8]; end
      2'h2:    begin rx_ch = rx_sh_r[8:1]; rx_parbit = 1'b0; end
      2'h1:    begin rx_ch = {1'b0, rx_sh_r[7:1]}; rx_parbit = rx_sh_r[8]; end
      default: begin rx_ch = {1'b0, rx_sh_r[8:2]}; rx_parbit = 1'b0; end
    endcase
  end

  assign par_exp = (par_mode == `ASX_PAR_ODD) ? ~(^rx_ch) : ^rx_ch;
  assign rx_perr = (par_mode == `ASX_PAR_ODD || par_mode == `ASX_PAR_EVEN)
                 && (rx_parbit != par_exp);
  assign rx_ferr = !rx_lvl_r;

  // frame word: parity error, framing error, data
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_frame <= 11'h000;
    end else if (ser_tick && rx_st_r == ASX_RX_DATA && rx_tick_r == `ASX_LAST_TICK && rx_idx_r == rx_last) begin
      rx_frame <= {1'b0, rx_perr, rx_ferr, rx_ch};
    end
  end

  asx_skid #(.WIDTH(11)) u_buf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (rx_done),
    .in_ready  (fb_ready),
    .in_data   (rx_frame),
    .out_valid (fb_valid),
    .out_ready (1'b1),
    .out_data  (fb_data)
  );

  // ****************************************
  // receive buffer and status
  // ****************************************
  logic unread_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      receive_buffer  <= 8'h00;
      rx_error_status <= 8'h00;
      unread_r        <= 1'b0;
      rx_end_irq      <= 1'b0;
      rx_error_irq    <= 1'b0;
    end else begin
      rx_end_irq   <= 1'b0;
      rx_error_irq <= 1'b0;
      if (fb_valid) begin // load wins over a same-cycle read
        receive_buffer  <= fb_data[7:0];
        rx_error_status <= {5'h00, unread_r, fb_data[8], fb_data[9]};
        unread_r        <= 1'b1;
        rx_end_irq      <= 1'b1;
        rx_error_irq    <= unread_r | fb_data[8] | fb_data[9];
      end else if (rx_rd) begin
        rx_error_status <= 8'h00;
        unread_r        <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_mode_top_set: assert property (@(posedge clk) disable iff (reset) uart_mode_reg[`ASX_MODE_TOP])
    else $error("mode top bit low");
  a_status_upper_zero: assert property (@(posedge clk) disable iff (reset) rx_error_status[7:3] == 5'h00)
    else $error("status upper bits set");
  a_err_with_end: assert property (@(posedge clk) disable iff (reset) rx_error_irq |-> rx_end_irq)
    else $error("error request without end request");
  a_err_flag_match: assert property (@(posedge clk) disable iff (reset)
    rx_error_irq |-> rx_error_status[2:0] != 3'h0)
    else $error("error request without flag");
  a_tx_start_low: assert property (@(posedge clk) disable iff (reset)
    (tx_wr && !tx_busy) |=> (txd == 1'b0 && tx_busy))
    else $error("frame did not start");
  a_tx_end_idle: assert property (@(posedge clk) disable iff (reset)
    tx_end_irq |-> (!tx_busy && txd && $past(tx_busy)))
    else $error("end request without frame");
  a_rx_disabled_quiet: assert property (@(posedge clk) disable iff (reset)
    (!receive_enable_bit && rx_st_r != ASX_RX_IDLE) |=> rx_st_r == ASX_RX_IDLE)
    else $error("receiver ran while disabled");
  a_read_clears: assert property (@(posedge clk) disable iff (reset)
    (rx_rd && !fb_valid) |=> rx_error_status == 8'h00)
    else $error("read did not clear status");
  a_zero_parity_ok: assert property (@(posedge clk) disable iff (reset)
    (fb_valid && par_mode == `ASX_PAR_ZERO) |=> !rx_error_status[`ASX_ERR_PARITY])
    else $error("parity error in zero mode");
endmodule

/* hw/asx_skid.sv */
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   ready on the input side is decoded from the registered entry count
`timescale 1ns/100ps
module asx_skid #(
  parameter int WIDTH = 11
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wp_r;
  logic             rp_r;
  logic [1:0]       cnt_r;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* inc/asx_map.svh */
// Purpose: named constants of the serial core
// Assumes: included by the core module and the test bench
// Notes:   mode and status field positions, reset values
`ifndef ASX_MAP_SVH
`define ASX_MAP_SVH
`define ASX_MODE_RESET     8'h80
`define ASX_MODE_TOP       7
`define ASX_MODE_RXE       6
`define ASX_MODE_PS_HI     5
`define ASX_MODE_PS_LO     4
`define ASX_MODE_CL        3
`define ASX_MODE_SL        2
`define ASX_ERR_OVERRUN    2
`define ASX_ERR_FRAMING    1
`define ASX_ERR_PARITY     0
`define ASX_PAR_NONE       2'h0
`define ASX_PAR_ZERO       2'h1
`define ASX_PAR_ODD        2'h2
`define ASX_PAR_EVEN       2'h3
`define ASX_OVERSAMPLE     5'h10
`define ASX_HALF_BIT       4'h7
`define ASX_LAST_TICK      4'hf
`endif

/* inc/asx_pkg.sv */
// Purpose: shared types of the serial core
// Assumes: nothing
// Notes:   state enumerations only
package asx_pkg;
  typedef enum logic [1:0] {ASX_TX_IDLE, ASX_TX_SHIFT} asx_tx_state_t;
  typedef enum logic [1:0] {ASX_RX_IDLE, ASX_RX_START, ASX_RX_DATA} asx_rx_state_t;
endpackage

/* test/asx_remote.sv */
// Purpose: remote serial device on the core's pins
// Assumes: ser_tick pulses sixteen times per bit time
// Notes:   line idles high between frames
`timescale 1ns/100ps
module asx_remote (
  // clock and serial clock enable
  input  wire logic clk,
  input  wire logic ser_tick,
  // serial pins
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;

  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff ser_tick);
  endtask

  // frame out lsb first, 16 ticks a bit, last bit may be cut short
  task automatic drive(input logic [11:0] bits, input int n, input int tail);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      ticks((i == n - 1) ? tail : 16);
    end
    rxd <= 1'b1;
  endtask

  // wait for a start edge, then sample mid bit
  task automatic grab(input int n, output logic [11:0] bits, output bit ok);
    int t;
    bits = '1;
    t = 0;
    while (txd !== 1'b0 && t < 4000) begin
      @(posedge clk);
      t++;
    end
    ok = (t < 4000);
    ticks(8);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      ticks(16);
    end
  endtask
endmodule

/* test/test_asx_core.sv */
// Purpose: self-checking bench of the serial core
// Assumes: remote model drives rxd and watches txd
// Notes:   ser_tick pulses every other clock
`timescale 1ns/100ps
`include "asx_map.svh"
module test_asx_core;
  logic        clk, reset, ser_tick, mode_wr, tx_wr, rx_rd;
  logic        rxd, txd, tx_busy, tx_end_irq, rx_end_irq, rx_error_irq;
  logic [7:0]  mode_wdata, tx_wdata, uart_mode_reg, receive_buffer, rx_error_status;
  logic [7:0]  modes [4];
  logic [11:0] f;
  int          errors, n_checks, n_te, n_re, n_ee, n_pair, re, te, n;

  asx_core u_dut (.clk(clk), .reset(reset), .ser_tick(ser_tick), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .uart_mode_reg(uart_mode_reg), .tx_wr(tx_wr), .tx_wdata(tx_wdata),
    .txd(txd), .tx_busy(tx_busy), .tx_end_irq(tx_end_irq), .rxd(rxd), .rx_rd(rx_rd),
    .receive_buffer(receive_buffer), .rx_error_status(rx_error_status),
    .rx_end_irq(rx_end_irq), .rx_error_irq(rx_error_irq));
  asx_remote u_rem (.clk(clk), .ser_tick(ser_tick), .txd(txd), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // same serial rate on both ends
  always @(posedge clk) ser_tick <= ~ser_tick;
  always @(posedge clk) begin
    n_te   <= n_te + (tx_end_irq === 1'b1);
    n_re   <= n_re + (rx_end_irq === 1'b1);
    n_ee   <= n_ee + (rx_error_irq === 1'b1);
    n_pair <= n_pair + (rx_error_irq === 1'b1 && rx_end_irq === 1'b1);
  end

  // ****************
  // shared tasks
  // ****************
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic fail;
    errors++;
    conclude();
  endtask
  task automatic setmode(input logic [7:0] m);
    mode_wr    <= 1'b1;
    mode_wdata <= m;
    @(posedge clk);
    mode_wr    <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send(input logic [7:0] d);
    tx_wr    <= 1'b1;
    tx_wdata <= d;
    @(posedge clk);
    tx_wr    <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd;
    rx_rd <= 1'b1;
    @(posedge clk);
    rx_rd <= 1'b0;
    @(posedge clk);
  endtask
  // expected line bits: start, data lsb first, parity, stops
  function automatic logic [11:0] frame(input logic [7:0] m, input logic [7:0] d, output int n);
    logic [11:0] r;
    logic        p;
    int          k;
    k = m[`ASX_MODE_CL] ? 8 : 7;
    p = m[`ASX_MODE_CL] ? ^d : ^d[6:0];
    r = 12'hfff;
    r[0] = 1'b0;
    for (int i = 0; i < k; i++) r[i+1] = d[i];
    n = k + 1;
    if (m[5:4] != `ASX_PAR_NONE) begin
      r[n] = (m[5:4] == `ASX_PAR_ZERO) ? 1'b0 : ((m[5:4] == `ASX_PAR_ODD) ? ~p : p);
      n++;
    end
    n = n + 1 + m[`ASX_MODE_SL];
    return r;
  endfunction

  // ****************
  // scenarios
  // ****************
  task automatic t_tx(input logic [7:0] m, input logic [7:0] d);
    logic [11:0] got, exp;
    bit          ok;
    int          k, t0;
    exp = frame(m, d, k);
    setmode(m);
    t0 = n_te;
    fork
      u_rem.grab(k, got, ok);
      begin
        send(d);
        #1 check(tx_busy, 1'b1);
        @(posedge clk);
        send(~d);
      end
    join
    if (!ok) fail();
    k = 0;
    while (tx_busy !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) fail();
    repeat (4) @(posedge clk);
    check(got, exp);
    check(12'(n_te - t0), 12'h001);
    $display("tx test mode %h done", m);
  endtask

  task automatic t_rx(input logic [7:0] m, d, input logic [11:0] flip, input int tail,
                      input logic [7:0] st);
    logic [11:0] g;
    int          k, r0, e0;
    g  = frame(m, d, k) ^ flip;
    r0 = n_re;
    e0 = n_ee;
    setmode(m);
    u_rem.drive(g, k, tail);
    repeat (8) @(posedge clk);
    #1 check(receive_buffer, d);
    check(rx_error_status, st);
    check(12'(n_re - r0), 12'h001);
    check(12'(n_ee - e0), st != 8'h00);
    check(12'(n_pair), 12'(n_ee));
    @(posedge clk);
    $display("rx test data %h done", d);
  endtask

  task automatic t_glitch;
    re = n_re;
    u_rem.drive(12'h000, 1, 4);
    repeat (400) @(posedge clk);
    #1 check(12'(n_re - re), 12'h000);
    @(posedge clk);
    $display("start glitch test done");
  endtask

  task automatic t_abort;
    int e0;
    re = n_re;
    e0 = n_ee;
    f  = frame(8'hc8, 8'h55, n);
    fork
      u_rem.drive(f, n, 16);
      begin
        repeat (120) @(posedge clk);
        setmode(8'h88);
      end
    join
    repeat (40) @(posedge clk);
    #1 check(12'(n_re - re), 12'h000);
    check(12'(n_ee - e0), 12'h000);
    check(receive_buffer, 8'h7e);
    check(rx_error_status, 8'h00);
    @(posedge clk);
    $display("receive abort test done");
  endtask

  task automatic t_reset;
    send(8'h5a);
    repeat (60) @(posedge clk);
    te = n_te;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (600) @(posedge clk);
    #1 check(12'(n_te - te), 12'h000);
    check(txd, 1'b1);
    check(tx_busy, 1'b0);
    @(posedge clk);
    $display("mid-run reset test done");
  endtask

  initial begin
    {reset, ser_tick, mode_wr, tx_wr, rx_rd} = 5'h10;
    mode_wdata = 8'h00;
    tx_wdata   = 8'h00;
    {errors, n_checks, n_te, n_re, n_ee, n_pair} = '0;
    modes = '{8'h88, 8'hbc, 8'ha0, 8'h90};
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 check(uart_mode_reg, `ASX_MODE_RESET);
    check(txd, 1'b1);
    @(posedge clk);
    setmode(8'h00);
    #1 check(uart_mode_reg, 8'h80);
    @(posedge clk);
    // second character written while each frame is still shifting out
    for (int i = 0; i < 4; i++) t_tx(modes[i], 8'hd3);
    t_rx(8'hc8, 8'ha5, 12'h000, 16, 8'h00);
    t_rx(8'hf8, 8'h3c, 12'h200, 16, 8'h05);
    rd();
    #1 check(rx_error_status, 8'h00);
    @(posedge clk);
    t_rx(8'hc8, 8'h0f, 12'h200, 10, 8'h02);
    t_rx(8'hc8, 8'h81, 12'h000, 16, 8'h04);
    rd();
    t_rx(8'hd8, 8'h7e, 12'h200, 16, 8'h00);
    t_glitch();
    t_abort();
    t_reset();
    conclude();
  end
endmodule
